// [testbench/ebc_ctl_assertions.sv]
`timescale 1ns/100ps

// ****************************************
// Pin level checks on the bus controller
// ****************************************
module ebc_ctl_checker #(
  parameter ADDR_W = 24,
  parameter BANKS = 4
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [2:0] processor_id,
  input wire logic ack_out,
  input wire logic ack_oe,
  input wire logic io_slave_access,
  input wire logic io_slave_ready,
  input wire logic bus_suspend_tristate_n,
  input wire logic system_input_clock,
  input wire logic burst_continue_out,
  input wire logic burst_continue_oe,
  input wire logic mem_clock_out_0,
  input wire logic mem_clock_out_1,
  input wire logic burst_keeper_en,
  input wire logic [ADDR_W-1:0] addr_out,
  input wire logic addr_oe,
  input wire logic data_oe,
  input wire logic [BANKS-1:0] bank_select_n,
  input wire logic select_oe,
  input wire logic rd_n,
  input wire logic strobe_oe,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic sdram_write_enable_n,
  input wire logic data_mask,
  input wire logic mem_clock_oe_0,
  input wire logic mem_clock_oe_1,
  input wire logic mem_clock_float_1,
  input wire logic mem_clock_float_all,
  input wire logic rd_valid,
  input wire logic bus_stalled
);
  logic [5:0] susp_cnt;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Suspend only bites at a bus clock rise, so count past two of them
  always @(posedge clock) begin
    if (!reset_n || bus_suspend_tristate_n)
      susp_cnt <= 6'h0;
    else if (susp_cnt != 6'h3f)
      susp_cnt <= susp_cnt + 6'h1;
  end
  float_on_susp_a: assert property (susp_cnt > 6'h28 |-> !addr_oe && !data_oe && !select_oe && !strobe_oe)
    else $error("bus driven while suspended");
  stall_on_susp_a: assert property (susp_cnt > 6'h28 |-> !rd_valid)
    else $error("word completed while suspended");
  addr_held_a: assert property (addr_oe && $past(addr_oe) |-> $stable(addr_out))
    else $error("address moved inside a burst");
  sel_decode_a: assert property (!rd_n |-> bank_select_n == ~(4'h1 << addr_out[ADDR_W-1 -: 2]))
    else $error("bank select does not match address");
  sel_release_a: assert property ($rose(rd_n) |-> bank_select_n == 4'hf)
    else $error("bank select held after last word");
  burst_first_a: assert property ($fell(rd_n) |-> !burst_continue_out)
    else $error("burst flag set on first access");
  burst_last_a: assert property ($rose(rd_n) |-> !$past(burst_continue_out))
    else $error("burst flag set on final word");
  keeper_id_a: assert property ($stable(processor_id)[*7] |-> burst_keeper_en == (processor_id[2:1] == 2'h0))
    else $error("keeper enable wrong for id");
  clock_float_a: assert property (mem_clock_oe_0 == !mem_clock_float_all && mem_clock_oe_1 == !(mem_clock_float_all || mem_clock_float_1))
    else $error("memory clock enable wrong");
  mem_clock_a: assert property ($past(system_input_clock, 3) == mem_clock_out_0 && mem_clock_out_0 == mem_clock_out_1)
    else $error("memory clock does not follow input clock");
  keeper_hold_a: assert property (!burst_continue_oe |-> $stable(burst_continue_out))
    else $error("burst level not held while released");
  ack_pull_a: assert property ((io_slave_access && !io_slave_ready)[*5] |-> ack_oe && !ack_out)
    else $error("acknowledge not pulled low");
  ack_free_a: assert property (!io_slave_access[*5] |-> !ack_oe)
    else $error("acknowledge driven while not accessed");
  mask_pre_a: assert property ($fell(ras_n) && cas_n && !sdram_write_enable_n |=> data_mask)
    else $error("mask not set for precharge");
  cover property (rd_valid && burst_continue_out);
  cover property (susp_cnt > 6'h28 && bus_stalled);
  cover property ($fell(ras_n) && cas_n && !sdram_write_enable_n);
  cover property (ack_oe);
endmodule

bind ebc_ctl ebc_ctl_checker #(.ADDR_W(ADDR_W), .BANKS(BANKS)) u_ebc_ctl_checker (.*);

// [testbench/ebc_mem_model.sv]
`timescale 1ns/100ps

// ****************************************
// Burst capable memory on the far side
// ****************************************
module ebc_mem_model (
  input wire logic sysclk,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic susp_n,
  input wire logic slow,
  input wire logic [23:0] addr,
  input wire logic [31:0] wdata,
  output logic ack,
  output logic [31:0] rdata
);
  logic busy;
  logic susp_d;
  logic [23:0] cnt;
  logic [31:0] wq[$];
  function automatic logic [31:0] fill_word(input logic [23:0] a);
    return {8'h00, a} ^ 32'h3c96a5e1;
  endfunction
  initial begin
    ack = 1'b1;
    rdata = 32'h0;
    busy = 1'b0;
    susp_d = 1'b1;
    cnt = 24'h0;
  end
  // Strobes float while suspended, so a burst is only over once the bus is back
  always @(posedge sysclk) begin
    susp_d <= susp_n;
    if (rd_n && wr_n) begin
      if (susp_n && susp_d)
        busy <= 1'b0;
    end else if (ack && susp_n) begin
      if (!wr_n)
        wq.push_back(wdata);
      cnt <= (busy ? cnt : addr) + 24'h1;
      busy <= 1'b1;
    end else if (!busy) begin
      cnt <= addr;
      busy <= 1'b1;
    end
  end
  // Wait state after a suspend keeps the resume rise from completing a word
  always @(negedge sysclk) begin
    ack <= (slow ? !ack : 1'b1) && susp_d;
    rdata <= !rd_n ? fill_word(busy ? cnt : addr) : ~rdata;
  end
endmodule

// [testbench/tb_top.sv]
`timescale 1ns/100ps

// ****************************************
// Bench for the bus controller
// ****************************************
module tb_top;
  logic clock, reset_n, system_input_clock, bus_suspend_tristate_n, slow, p_ack;
  logic mem_clock_float_1, mem_clock_float_all, io_slave_access, io_slave_ready;
  logic req_valid, req_write, req_sdram, wr_valid, sd_cmd_valid, sd_cmd_a10, sd_init_active;
  logic req_ready, wr_ready, rd_valid, sd_cmd_ready, bus_stalled, ack_out, ack_oe;
  logic burst_continue_out, burst_continue_oe, burst_keeper_en, addr_oe, data_oe, select_oe;
  logic rd_n, wr_n, strobe_oe, ras_n, cas_n, sdram_write_enable_n, sdram_addr_bit10, data_mask;
  logic mem_clock_out_0, mem_clock_out_1, mem_clock_oe_0, mem_clock_oe_1;
  logic [2:0] processor_id, sd_cmd_code;
  logic [1:0] sd_cmd_bank;
  logic [3:0] req_len, bank_select_n;
  logic [23:0] req_addr, addr_out;
  logic [31:0] data_out, wr_data, rd_data, p_data;
  wire ack_in = p_ack && !(ack_oe && !ack_out);
  wire [31:0] data_in = data_oe ? data_out : p_data;
  logic [31:0] exp_q[$], wexp[$];
  logic [2:0] pats [7] = '{3'h7, 3'h3, 3'h5, 3'h4, 3'h2, 3'h1, 3'h0};
  int error_cnt, checks, cyc, k, n;
  ebc_ctl u_ebc_ctl (.*);
  ebc_mem_model u_ebc_mem_model (
    .sysclk(system_input_clock),
    .rd_n(rd_n || !strobe_oe),
    .wr_n(wr_n || !strobe_oe),
    .susp_n(bus_suspend_tristate_n),
    .slow(slow),
    .addr(addr_out),
    .wdata(data_in),
    .ack(p_ack),
    .rdata(p_data)
  );
  function automatic logic [31:0] word_of(input logic [23:0] a);
    return {8'h00, a} ^ 32'h3c96a5e1;
  endfunction
  task automatic chk(input bit ok, input string m);
    checks++;
    if (!ok) begin
      error_cnt++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask
  task automatic test_done;
    if (error_cnt == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic req(input logic w, input logic [23:0] a, input logic [3:0] len);
    int j;
    @(posedge clock);
    #1;
    req_valid = 1'b1;
    req_write = w;
    req_sdram = 1'($urandom);
    req_addr = a;
    req_len = len;
    for (j = 0; j <= len && !w; j++)
      exp_q.push_back(word_of(a + 24'(j)));
    j = 0;
    do @(negedge clock); while (req_ready !== 1'b1 && ++j < 400);
    @(posedge clock);
    #1;
    req_valid = 1'b0;
    @(negedge clock);
    chk(sdram_addr_bit10 === (req_sdram & a[10]) && (rd_n & wr_n) === 1'b0 &&
        burst_continue_oe === 1'b1, "access start");
  endtask
  task automatic wait_idle;
    int j;
    for (j = 0; j < 4000 && (rd_n & wr_n & !addr_oe & !bus_stalled) !== 1'b1; j++)
      @(negedge clock);
    repeat (3) @(negedge clock);
  endtask
  task automatic push(input logic [31:0] d);
    int j;
    wr_valid = 1'b1;
    wr_data = d;
    wexp.push_back(d);
    j = 0;
    do @(negedge clock); while (wr_ready !== 1'b1 && ++j < 100);
    @(posedge clock);
    #1;
  endtask
  task automatic suspend(input logic v);
    @(negedge system_input_clock);
    @(posedge clock);
    #1;
    bus_suspend_tristate_n = v;
  endtask
  task automatic cmd(input logic [2:0] c, input logic [1:0] b, input logic [2:0] pat);
    int j;
    @(posedge clock);
    #1;
    sd_cmd_valid = 1'b1;
    sd_cmd_code = c;
    sd_cmd_bank = b;
    sd_cmd_a10 = 1'($urandom);
    j = 0;
    do @(negedge clock); while (sd_cmd_ready !== 1'b1 && ++j < 400);
    @(posedge clock);
    #1;
    sd_cmd_valid = 1'b0;
    @(negedge clock);
    chk({ras_n, cas_n, sdram_write_enable_n, bank_select_n} === {pat, ~(4'h1 << b)}, "command");
    chk(sdram_addr_bit10 === sd_cmd_a10, "command bit 10");
    @(negedge clock);
    chk(c != 3'h4 || data_mask === 1'b1, "precharge mask");
  endtask
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    system_input_clock = 1'b0;
    #3.3;
    forever #62.5 system_input_clock = ~system_input_clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (rd_valid === 1'b1) begin
      chk(exp_q.size() > 0 && rd_data === exp_q.pop_front(), "read word");
      chk(burst_continue_out === (exp_q.size() > 1), "burst flag");
    end
    if (cyc == 40000) begin
      chk(1'b0, "timeout");
      test_done();
    end
  end
  initial begin
    void'($urandom(32'h55d1246b));
    {reset_n, req_valid, req_write, req_sdram, wr_valid, sd_cmd_valid, sd_cmd_a10} = '0;
    {slow, mem_clock_float_1, mem_clock_float_all, io_slave_access, io_slave_ready} = '0;
    {req_addr, req_len, wr_data, sd_cmd_code, sd_cmd_bank} = '0;
    bus_suspend_tristate_n = 1'b1;
    sd_init_active = 1'b1;
    processor_id = 3'($urandom);
    repeat (5) @(posedge clock);
    @(negedge clock);
    chk(data_mask === 1'b1 && {bank_select_n, ras_n, cas_n, rd_n} === 7'h7f, "reset levels");
    @(posedge clock);
    #1;
    reset_n = 1'b1;
    repeat (8) @(negedge clock);
    chk(data_mask === 1'b1, "init mask");
    for (k = 0; k < 4; k++) begin
      @(posedge clock);
      #1;
      sd_init_active = 1'b0;
      {mem_clock_float_all, mem_clock_float_1} = 2'(k);
      processor_id = 3'($urandom);
      repeat (6) @(negedge clock);
      chk(mem_clock_oe_0 === !k[1] && mem_clock_oe_1 === (k == 0), "clock float");
      chk(burst_keeper_en === (processor_id[2:1] == 2'h0), "keeper");
    end
    for (k = 0; k < 8; k++) begin
      slow = k[0];
      req(1'b0, 24'($urandom), (k == 7) ? 4'hf : 4'($urandom_range(6)));
      wait_idle();
      chk(exp_q.size() == 0, "word count");
    end
    for (k = 1; k < 7; k++)
      cmd(3'(k), 2'($urandom), pats[k]);
    @(posedge clock);
    #1;
    io_slave_access = 1'b1;
    repeat (6) @(negedge clock);
    chk(ack_oe === 1'b1 && ack_in === 1'b0, "ack hold");
    @(posedge clock);
    #1;
    io_slave_ready = 1'b1;
    repeat (6) @(negedge clock);
    chk(ack_oe === 1'b0, "ack release");
    @(posedge clock);
    #1;
    for (k = 0; k < 16; k++)
      push($urandom);
    wr_valid = 1'b0;
    @(negedge clock);
    chk(wr_ready === 1'b0, "buffer full");
    slow = 1'b1;
    req(1'b1, 24'($urandom), 4'hf);
    repeat (100) @(posedge clock);
    suspend(1'b0);
    repeat (40) @(posedge clock);
    n = u_ebc_mem_model.wq.size();
    repeat (300) @(negedge clock);
    chk({addr_oe, data_oe, select_oe, strobe_oe} === 4'h0, "bus floated");
    chk(bus_stalled === 1'b1 && n == u_ebc_mem_model.wq.size(), "stall");
    suspend(1'b1);
    wait_idle();
    chk(u_ebc_mem_model.wq.size() == 16 && wr_ready === 1'b1, "write count");
    for (k = 0; k < 16; k++)
      chk(u_ebc_mem_model.wq[k] === wexp[k], "write word");
    test_done();
  end
endmodule

// [verilog/ebc_ctl.v]
// Contract
// - Burst-continue marks data belonging to consecutive burst addresses.
// - Address is not advanced on the bus during a burst.
// - Burst reads are allowed, including of slave processor port buffers.
// - Burst-continue high after first access, low on the final data cycle.
// - Burst-continue keeper holds last level, only for processor id 00x.
// - Device pulls acknowledge low while its own io registers are not ready.
// - Suspend sampled low floats address, data, selects, strobes next cycle.
// - Access attempted during suspend stalls until suspend is released.
// - Memory commands encoded on row, column, write strobes, selects, bit 10.
// - Data mask zero latency on writes, set for precharge and power-up init.
// - Second memory clock; clock one alone or both may float.
// - Bank select asserts with address, releases after acknowledge sampled high.
// - Memory bit 10 output replaces address bit 10 only in memory accesses.
`timescale 1ns/100ps
`include "ebc_regs.vh"

module ebc_ctl #(
  parameter ADDR_W = `EBC_ADDR_W,
  parameter DATA_W = `EBC_DATA_W,
  parameter BANKS = `EBC_BANKS,
  parameter LEN_W = `EBC_LEN_W,
  parameter FIFO_DEPTH = `EBC_FIFO_DEPTH
) (
  clock,
  reset_n,
  system_input_clock,
  processor_id,
  ack_in,
  ack_out,
  ack_oe,
  bus_suspend_tristate_n,
  burst_continue_out,
  burst_continue_oe,
  burst_keeper_en,
  addr_out,
  addr_oe,
  data_out,
  data_in,
  data_oe,
  bank_select_n,
  select_oe,
  rd_n,
  wr_n,
  strobe_oe,
  ras_n,
  cas_n,
  sdram_write_enable_n,
  sdram_addr_bit10,
  data_mask,
  mem_clock_out_0,
  mem_clock_out_1,
  mem_clock_oe_0,
  mem_clock_oe_1,
  mem_clock_float_1,
  mem_clock_float_all,
  io_slave_access,
  io_slave_ready,
  req_valid,
  req_ready,
  req_write,
  req_sdram,
  req_addr,
  req_len,
  wr_valid,
  wr_ready,
  wr_data,
  rd_valid,
  rd_data,
  sd_cmd_valid,
  sd_cmd_ready,
  sd_cmd_code,
  sd_cmd_bank,
  sd_cmd_a10,
  sd_init_active,
  bus_stalled
);
  input wire clock;
  input wire reset_n;
  input wire system_input_clock;
  input wire [2:0] processor_id;
  input wire ack_in;
  output wire ack_out;
  output wire ack_oe;
  input wire bus_suspend_tristate_n;
  output wire burst_continue_out;
  output wire burst_continue_oe;
  output wire burst_keeper_en;
  output wire [ADDR_W-1:0] addr_out;
  output wire addr_oe;
  output wire [DATA_W-1:0] data_out;
  input wire [DATA_W-1:0] data_in;
  output wire data_oe;
  output wire [BANKS-1:0] bank_select_n;
  output wire select_oe;
  output wire rd_n;
  output wire wr_n;
  output wire strobe_oe;
  output wire ras_n;
  output wire cas_n;
  output wire sdram_write_enable_n;
  output wire sdram_addr_bit10;
  output wire data_mask;
  output wire mem_clock_out_0;
  output wire mem_clock_out_1;
  output wire mem_clock_oe_0;
  output wire mem_clock_oe_1;
  input wire mem_clock_float_1;
  input wire mem_clock_float_all;
  input wire io_slave_access;
  input wire io_slave_ready;
  input wire req_valid;
  output wire req_ready;
  input wire req_write;
  input wire req_sdram;
  input wire [ADDR_W-1:0] req_addr;
  input wire [LEN_W-1:0] req_len;
  input wire wr_valid;
  output wire wr_ready;
  input wire [DATA_W-1:0] wr_data;
  output wire rd_valid;
  output wire [DATA_W-1:0] rd_data;
  input wire sd_cmd_valid;
  output wire sd_cmd_ready;
  input wire [2:0] sd_cmd_code;
  input wire [1:0] sd_cmd_bank;
  input wire sd_cmd_a10;
  input wire sd_init_active;
  output wire bus_stalled;

  // ****************************************
  // Helper functions
  // ****************************************
  function [2:0] cmd_strobes;
    input [2:0] code;
    begin
      case (code)
        `EBC_CMD_ACTIVATE: cmd_strobes = `EBC_RCW_ACTIVATE;
        `EBC_CMD_READ: cmd_strobes = `EBC_RCW_READ;
        `EBC_CMD_WRITE: cmd_strobes = `EBC_RCW_WRITE;
        `EBC_CMD_PRECHARGE: cmd_strobes = `EBC_RCW_PRECHARGE;
        `EBC_CMD_REFRESH: cmd_strobes = `EBC_RCW_REFRESH;
        `EBC_CMD_MODE_SET: cmd_strobes = `EBC_RCW_MODE_SET;
        default: cmd_strobes = `EBC_RCW_NOP;
      endcase
    end
  endfunction

  // One-hot active-low bank select from a two-bit bank: the top two address bits or sd_cmd_bank
  function [BANKS-1:0] bank_decode;
    input [1:0] bank;
    begin
      bank_decode = ~({{(BANKS-1){1'b0}}, 1'b1} << bank);
    end
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  wire [6:0] pins_sync;
  wire [DATA_W-1:0] data_in_sync;
  wire clk_s;
  wire ack_s;
  wire susp_n_s;
  wire io_acc_s;
  wire [2:0] id_s;

  ebc_sync2 #(.WIDTH(7)) u_sync_ctl (
    .clock(clock),
    .reset_n(reset_n),
    .async_in({processor_id, io_slave_access, bus_suspend_tristate_n, ack_in,
               system_input_clock}),
    .sync_out(pins_sync)
  );

  ebc_sync2 #(.WIDTH(DATA_W)) u_sync_data (
    .clock(clock),
    .reset_n(reset_n),
    .async_in(data_in),
    .sync_out(data_in_sync)
  );

  assign clk_s = pins_sync[0];
  assign ack_s = pins_sync[1];
  assign susp_n_s = pins_sync[2];
  assign io_acc_s = pins_sync[3];
  assign id_s = pins_sync[6:4];

  // ****************************************
  // Write data FIFO
  // ****************************************
  wire fifo_valid;
  wire [DATA_W-1:0] fifo_data;
  reg pop_now;

  ebc_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH), .AW(4)) u_fifo (
    .clock(clock),
    .reset_n(reset_n),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data(wr_data),
    .out_valid(fifo_valid),
    .out_ready(pop_now),
    .out_data(fifo_data)
  );

  // ****************************************
  // Input clock edge and sequencer state
  // ****************************************
  reg clk_d_reg;
  reg [1:0] state_reg;
  reg susp_reg;
  reg [ADDR_W-1:0] addr_reg;
  reg write_reg;
  reg [LEN_W-1:0] last_reg;
  reg [LEN_W-1:0] cnt_reg;
  reg burst_reg;
  reg loaded_reg;
  reg [DATA_W-1:0] dout_reg;
  reg [DATA_W-1:0] rd_data_reg;
  reg rd_valid_reg;
  reg [2:0] rcw_reg;
  reg [BANKS-1:0] sel_reg;
  reg a10_reg;
  reg mask_reg;
  reg ack_drive_reg;
  reg keep_reg;
  reg mclk_reg;

  wire clk_rise;
  wire busy;
  wire complete;
  wire last_word;

  assign clk_rise = clk_s && !clk_d_reg;
  assign busy = (state_reg != `EBC_ST_IDLE);
  assign last_word = (cnt_reg == last_reg);
  // Completion needs ack high at the edge, no suspend and a word to write
  assign complete = clk_rise && (state_reg == `EBC_ST_XFER) && ack_s && susp_n_s &&
                    (!write_reg || loaded_reg);
  assign req_ready = clk_rise && (state_reg == `EBC_ST_IDLE) && susp_n_s &&
                     !sd_cmd_valid && (!req_write || fifo_valid);
  assign sd_cmd_ready = clk_rise && (state_reg == `EBC_ST_IDLE) && susp_n_s;

  always @* begin
    pop_now = 1'b0;
    if (req_valid && req_ready && req_write) begin
      pop_now = 1'b1;
    end else if (state_reg == `EBC_ST_XFER && write_reg && fifo_valid &&
                 (complete ? !last_word : !loaded_reg)) begin
      pop_now = 1'b1;
    end
  end

  always @(posedge clock) begin
    if (!reset_n) begin
      clk_d_reg <= 1'b0;
      state_reg <= `EBC_ST_IDLE;
      susp_reg <= 1'b0;
      addr_reg <= {ADDR_W{1'b0}};
      write_reg <= 1'b0;
      last_reg <= {LEN_W{1'b0}};
      cnt_reg <= {LEN_W{1'b0}};
      burst_reg <= 1'b0;
      loaded_reg <= 1'b0;
      dout_reg <= {DATA_W{1'b0}};
      rd_data_reg <= {DATA_W{1'b0}};
      rd_valid_reg <= 1'b0;
      rcw_reg <= `EBC_RCW_NOP;
      sel_reg <= {BANKS{1'b1}};
      a10_reg <= 1'b0;
      mask_reg <= 1'b1;
      ack_drive_reg <= 1'b0;
      keep_reg <= 1'b0;
      mclk_reg <= 1'b0;
    end else begin
      clk_d_reg <= clk_s;
      mclk_reg <= clk_s;
      rd_valid_reg <= 1'b0;
      // Io registers not ready: hold the other master off
      ack_drive_reg <= io_acc_s && !io_slave_ready;
      if (clk_rise) begin
        susp_reg <= !susp_n_s;
      end
      if (burst_continue_oe) begin
        keep_reg <= burst_reg;
      end
      if (pop_now) begin
        dout_reg <= fifo_data;
        loaded_reg <= 1'b1;
      end else if (complete) begin
        loaded_reg <= 1'b0;
      end
      mask_reg <= sd_init_active || (state_reg == `EBC_ST_SDCMD &&
                  rcw_reg == `EBC_RCW_PRECHARGE);
      case (state_reg)
        `EBC_ST_IDLE: begin
          if (sd_cmd_valid && sd_cmd_ready) begin
            rcw_reg <= cmd_strobes(sd_cmd_code);
            sel_reg <= bank_decode(sd_cmd_bank);
            a10_reg <= sd_cmd_a10;
            state_reg <= `EBC_ST_SDCMD;
          end else if (req_valid && req_ready) begin
            // Address is driven once and held for the whole burst
            addr_reg <= req_addr;
            write_reg <= req_write;
            last_reg <= req_len;
            cnt_reg <= {LEN_W{1'b0}};
            burst_reg <= 1'b0;
            sel_reg <= bank_decode(req_addr[ADDR_W-1:ADDR_W-2]);
            a10_reg <= req_sdram ? req_addr[`EBC_ADDR_BIT10] : 1'b0;
            rcw_reg <= req_sdram ? (req_write ? `EBC_RCW_WRITE : `EBC_RCW_READ) :
                       `EBC_RCW_NOP;
            state_reg <= `EBC_ST_XFER;
          end
        end
        `EBC_ST_XFER: begin
          if (complete) begin
            if (!write_reg) begin
              rd_data_reg <= data_in_sync;
              rd_valid_reg <= 1'b1;
            end
            if (last_word) begin
              burst_reg <= 1'b0;
              sel_reg <= {BANKS{1'b1}};
              a10_reg <= 1'b0;
              rcw_reg <= `EBC_RCW_NOP;
              state_reg <= `EBC_ST_IDLE;
            end else begin
              cnt_reg <= cnt_reg + {{(LEN_W-1){1'b0}}, 1'b1};
              // High on middle words, low again for the final data cycle
              burst_reg <= (cnt_reg + {{(LEN_W-1){1'b0}}, 1'b1}) != last_reg;
            end
          end
        end
        `EBC_ST_SDCMD: begin
          // Command strobes stand until the next input clock rise with suspend released, one period unless suspended
          if (clk_rise && susp_n_s) begin
            rcw_reg <= `EBC_RCW_NOP;
            sel_reg <= {BANKS{1'b1}};
            a10_reg <= 1'b0;
            state_reg <= `EBC_ST_IDLE;
          end
        end
        default: begin
          state_reg <= `EBC_ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Pin drive
  // ****************************************
  assign addr_out = addr_reg;
  assign addr_oe = busy && !susp_reg;
  assign data_out = dout_reg;
  // Write data and mask leave together: zero-latency mask on writes
  assign data_oe = busy && write_reg && loaded_reg && !susp_reg;
  assign bank_select_n = sel_reg;
  assign select_oe = !susp_reg;
  assign rd_n = !(state_reg == `EBC_ST_XFER && !write_reg);
  assign wr_n = !(state_reg == `EBC_ST_XFER && write_reg && loaded_reg);
  assign strobe_oe = !susp_reg;
  assign ras_n = rcw_reg[2];
  assign cas_n = rcw_reg[1];
  assign sdram_write_enable_n = rcw_reg[0];
  assign sdram_addr_bit10 = a10_reg;
  assign data_mask = mask_reg;
  // Released pin shows the last driven level, as the keeper would hold it
  assign burst_continue_out = burst_continue_oe ? burst_reg : keep_reg;
  assign burst_continue_oe = (state_reg == `EBC_ST_XFER) && !susp_reg;
  assign burst_keeper_en = (id_s[2:1] == `EBC_KEEPER_ID_HI);
  assign ack_out = 1'b0;
  assign ack_oe = ack_drive_reg;
  assign mem_clock_out_0 = mclk_reg;
  assign mem_clock_out_1 = mclk_reg;
  assign mem_clock_oe_0 = !mem_clock_float_all;
  assign mem_clock_oe_1 = !(mem_clock_float_all || mem_clock_float_1);
  assign rd_valid = rd_valid_reg;
  assign rd_data = rd_data_reg;
  assign bus_stalled = busy && susp_reg;
endmodule

// [verilog/ebc_fifo.v]
`timescale 1ns/100ps

// ****************************************
// Write data FIFO
// ****************************************
module ebc_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  clock,
  reset_n,
  in_valid,
  in_ready,
  in_data,
  out_valid,
  out_ready,
  out_data
);
  input wire clock;
  input wire reset_n;
  input wire in_valid;
  output wire in_ready;
  input wire [WIDTH-1:0] in_data;
  output wire out_valid;
  input wire out_ready;
  output wire [WIDTH-1:0] out_data;

  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;

  wire push;
  wire pop;

  assign in_ready = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_reg[rd_ptr_reg];

  // Pointer wrap assumes DEPTH is a power of two
  always @(posedge clock) begin
    if (!reset_n) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
      end
    end
  end

  always @(posedge clock) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end
endmodule

// [verilog/ebc_regs.vh]
`ifndef EBC_REGS_VH
`define EBC_REGS_VH

// ****************************************
// Bus sequencer states
// ****************************************
`define EBC_ST_IDLE 2'h0
`define EBC_ST_XFER 2'h1
`define EBC_ST_SDCMD 2'h2

// ****************************************
// Memory command codes on sd_cmd_code
// ****************************************
`define EBC_CMD_NOP 3'h0
`define EBC_CMD_ACTIVATE 3'h1
`define EBC_CMD_READ 3'h2
`define EBC_CMD_WRITE 3'h3
`define EBC_CMD_PRECHARGE 3'h4
`define EBC_CMD_REFRESH 3'h5
`define EBC_CMD_MODE_SET 3'h6

// ****************************************
// Strobe patterns {ras_n, cas_n, we_n}
// ****************************************
`define EBC_RCW_NOP 3'h7
`define EBC_RCW_ACTIVATE 3'h3
`define EBC_RCW_READ 3'h5
`define EBC_RCW_WRITE 3'h4
`define EBC_RCW_PRECHARGE 3'h2
`define EBC_RCW_REFRESH 3'h1
`define EBC_RCW_MODE_SET 3'h0

// ****************************************
// Sizes and fixed values
// ****************************************
`define EBC_ADDR_W 24
`define EBC_DATA_W 32
`define EBC_BANKS 4
`define EBC_LEN_W 4
`define EBC_FIFO_DEPTH 16
`define EBC_KEEPER_ID_HI 2'h0
`define EBC_ADDR_BIT10 10

`endif

// [verilog/ebc_sync2.v]
`timescale 1ns/100ps

// ****************************************
// Two-stage synchroniser
// ****************************************
module ebc_sync2 #(
  parameter WIDTH = 1
) (
  clock,
  reset_n,
  async_in,
  sync_out
);
  input wire clock;
  input wire reset_n;
  input wire [WIDTH-1:0] async_in;
  output wire [WIDTH-1:0] sync_out;

  reg [WIDTH-1:0] stage1_reg;
  reg [WIDTH-1:0] stage2_reg;

  // Stage one feeds stage two only
  always @(posedge clock) begin
    if (!reset_n) begin
      stage1_reg <= {WIDTH{1'b0}};
      stage2_reg <= {WIDTH{1'b0}};
    end else begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_out = stage2_reg;
endmodule
